// ---- design/lmp_consts.svh ----
// Operation
// - five-bit count of DMA words left, minus one per 32-bit word loaded
// - port-B pins 7..0 enable bits make those pins row commons
// - port-B pins 15..8 enable bits make those pins row commons
// - port-B pins 23..16 enable bits make those pins row commons
// - bit 5 makes port-C pins 20..16 row commons
// - bit 4 enables port-C pins 15..8, bit 3 pins 7..0
// - bits 2,1,0 enable port-A pins 23..16, 15..8, 7..0
// - port-A and port-C rows get selection and fading, never inversion
// - column enables 7..1 switch their column onto three RGB pins
// - column 0 enable is read-only and always reads one
// - column enables 15..8 switch their RGB pins on or off
// - upper 27 bits of the DMA counter word (31..5) read as zero
// - six-bit row select chooses the one active row common
// - global PWM enable gates columns, auto-cleared on interrupt entry
`ifndef LMP_CONSTS_SVH
`define LMP_CONSTS_SVH
// register indices, byte address is four times the index
`define LMP_IDX_ROW_SEL     4'h0
`define LMP_IDX_KEY_CTRL    4'h1
`define LMP_IDX_PWM_OE      4'h2
`define LMP_IDX_DMA_LEFT    4'h3
`define LMP_IDX_COM_E       4'h4
`define LMP_IDX_COM_E_PBM   4'h5
`define LMP_IDX_COM_E_PBH   4'h6
`define LMP_IDX_COM_E_PAPC  4'h7
`define LMP_IDX_PWM_PIN     4'h8
`define LMP_IDX_FUNC_CTRL   4'hC
// field positions
`define LMP_BIT_PB_INV      3
`define LMP_BIT_PWM_OE      0
`define LMP_BIT_AUTO_CLR    2
// reset values
`define LMP_RST_BYTE        8'h00
`define LMP_RST_PIN_L       8'h01
`define LMP_RST_DMA         5'h00
`define LMP_RST_PAPC        6'h00
`define LMP_RST_COL         15'h0000
`define LMP_RST_SEL         6'h00
`endif

// ---- design/lmp_pkg.sv ----
package lmp_pkg;
    typedef struct packed {
        logic [20:0] pc;
        logic [23:0] pa;
        logic [23:0] pb;
    } lmp_row_s;
endpackage : lmp_pkg

// ---- design/lmp_top.sv ----
// The APB slave port was left to the implementer.
`include "lmp_consts.svh"

module lmp_top #(
    parameter int COLS = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             dma_word_loaded,
    input  wire logic             irq_entry,
    output lmp_pkg::lmp_row_s     row_drive,
    output logic      [5:0]       row_select,
    output logic      [COLS-1:0]  column_enable,
    output logic      [3*COLS-1:0] column_rgb_enable
);

    if (COLS != 16) begin : g_bad_cols
        $error("lmp_top serves sixteen columns only");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [4:0]  dma_word_counter;
    logic [7:0]  portb_low_row_enable;
    logic [7:0]  portb_mid_row_enable;
    logic [7:0]  portb_high_row_enable;
    logic [5:0]  papc_row_enable;
    logic [15:1] column_pwm_enable;
    logic [5:0]  row_sel;
    logic        pb_invert;
    logic        pwm_oe;
    logic        pwm_enable_auto_clear;

    logic [4:0]  next_dma_word_counter;
    logic [7:0]  next_pbl;
    logic [7:0]  next_pbm;
    logic [7:0]  next_pbh;
    logic [5:0]  next_papc;
    logic [15:1] next_col;
    logic [5:0]  next_row_sel;
    logic        next_pb_invert;
    logic        next_pwm_oe;
    logic        next_auto_clr;

    logic        wr_fire;
    logic [3:0]  idx;
    logic        mapped;
    logic [31:0] rd_word;
    logic [15:0] pin_word;
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    // ------------------------------------------------------------
    // apb decode, one wait state per access
    // ------------------------------------------------------------
    assign idx     = paddr[5:2];
    assign wr_fire = psel & penable & pready & pwrite;
    assign mapped  = (paddr[11:6] == 6'h00) &&
                     ((idx <= `LMP_IDX_PWM_PIN) || (idx == `LMP_IDX_FUNC_CTRL));
    assign pin_word = {column_pwm_enable, 1'b1};

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (idx)
            `LMP_IDX_ROW_SEL:    rd_word[5:0] = row_sel;
            `LMP_IDX_KEY_CTRL:   rd_word[`LMP_BIT_PB_INV] = pb_invert;
            `LMP_IDX_PWM_OE:     rd_word[`LMP_BIT_PWM_OE] = pwm_oe;
            `LMP_IDX_DMA_LEFT:   rd_word[4:0] = dma_word_counter;
            `LMP_IDX_COM_E:      rd_word = {2'b00, papc_row_enable, portb_high_row_enable,
                                            portb_mid_row_enable, portb_low_row_enable};
            `LMP_IDX_COM_E_PBM:  rd_word[7:0] = portb_mid_row_enable;
            `LMP_IDX_COM_E_PBH:  rd_word[7:0] = portb_high_row_enable;
            `LMP_IDX_COM_E_PAPC: rd_word[5:0] = papc_row_enable;
            `LMP_IDX_PWM_PIN:    rd_word[15:0] = pin_word;
            `LMP_IDX_FUNC_CTRL:  rd_word[`LMP_BIT_AUTO_CLR] = pwm_enable_auto_clear;
            default:             rd_word = 32'h0000_0000;
        endcase
    end

    // answer one cycle late: keeps the read mux off the pready path
    always_comb begin
        next_pready  = psel & penable & ~pready;
        next_pslverr = next_pready & ~mapped;
        next_prdata  = (next_pready & ~pwrite & mapped) ? rd_word : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    always_comb begin
        next_dma_word_counter = dma_word_counter;
        next_pbl       = portb_low_row_enable;
        next_pbm       = portb_mid_row_enable;
        next_pbh       = portb_high_row_enable;
        next_papc      = papc_row_enable;
        next_col       = column_pwm_enable;
        next_row_sel   = row_sel;
        next_pb_invert = pb_invert;
        next_pwm_oe    = pwm_oe;
        next_auto_clr  = pwm_enable_auto_clear;
        // software write wins over the count, the count stops at zero
        if (wr_fire && idx == `LMP_IDX_DMA_LEFT && pstrb[0]) begin
            next_dma_word_counter = pwdata[4:0];
        end else if (dma_word_loaded && dma_word_counter != 5'h00) begin
            next_dma_word_counter = dma_word_counter - 5'h01;
        end
        if (wr_fire && idx == `LMP_IDX_COM_E) begin
            if (pstrb[0]) next_pbl = pwdata[7:0];
            if (pstrb[1]) next_pbm = pwdata[15:8];
            if (pstrb[2]) next_pbh = pwdata[23:16];
            if (pstrb[3]) next_papc = pwdata[29:24];
        end
        if (wr_fire && idx == `LMP_IDX_COM_E_PBM && pstrb[0]) next_pbm = pwdata[7:0];
        if (wr_fire && idx == `LMP_IDX_COM_E_PBH && pstrb[0]) next_pbh = pwdata[7:0];
        if (wr_fire && idx == `LMP_IDX_COM_E_PAPC && pstrb[0]) next_papc = pwdata[5:0];
        if (wr_fire && idx == `LMP_IDX_PWM_PIN) begin
            if (pstrb[0]) next_col[7:1] = pwdata[7:1];
            if (pstrb[1]) next_col[15:8] = pwdata[15:8];
        end
        if (wr_fire && idx == `LMP_IDX_ROW_SEL && pstrb[0]) next_row_sel = pwdata[5:0];
        if (wr_fire && idx == `LMP_IDX_KEY_CTRL && pstrb[0]) begin
            next_pb_invert = pwdata[`LMP_BIT_PB_INV];
        end
        if (wr_fire && idx == `LMP_IDX_FUNC_CTRL && pstrb[0]) begin
            next_auto_clr = pwdata[`LMP_BIT_AUTO_CLR];
        end
        // a software write in the same cycle beats the auto-clear
        if (wr_fire && idx == `LMP_IDX_PWM_OE && pstrb[0]) begin
            next_pwm_oe = pwdata[`LMP_BIT_PWM_OE];
        end else if (irq_entry && pwm_enable_auto_clear) begin
            next_pwm_oe = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_word_counter      <= `LMP_RST_DMA;
            portb_low_row_enable  <= `LMP_RST_BYTE;
            portb_mid_row_enable  <= `LMP_RST_BYTE;
            portb_high_row_enable <= `LMP_RST_BYTE;
            papc_row_enable       <= `LMP_RST_PAPC;
            column_pwm_enable     <= `LMP_RST_COL;
            row_sel               <= `LMP_RST_SEL;
            pb_invert             <= 1'b0;
            pwm_oe                <= 1'b0;
            pwm_enable_auto_clear <= 1'b0;
        end else begin
            dma_word_counter      <= next_dma_word_counter;
            portb_low_row_enable  <= next_pbl;
            portb_mid_row_enable  <= next_pbm;
            portb_high_row_enable <= next_pbh;
            papc_row_enable       <= next_papc;
            column_pwm_enable     <= next_col;
            row_sel               <= next_row_sel;
            pb_invert             <= next_pb_invert;
            pwm_oe                <= next_pwm_oe;
            pwm_enable_auto_clear <= next_auto_clr;
        end
    end

    // ------------------------------------------------------------
    // row select decode and pin outputs
    // ------------------------------------------------------------
    function automatic lmp_pkg::lmp_row_s row_decode(input logic [5:0] code);
        lmp_pkg::lmp_row_s r;
        r = '0;
        if (code <= 6'h01) begin
            r.pc[18 + code[0]] = 1'b1;
        end else if (code >= 6'h02 && code <= 6'h05) begin
            // codes 2..5 land on pa16..19
            r.pa[5'(code - 6'h02) + 5'd16] = 1'b1;
        end else if (code >= 6'h08 && code <= 6'h0F) begin
            r.pb[16 + code[2:0]] = 1'b1;
        end else if (code >= 6'h10 && code <= 6'h1F) begin
            r.pb[code[3:0]] = 1'b1;
        end
        return r;
    endfunction : row_decode

    lmp_pkg::lmp_row_s row_en;
    lmp_pkg::lmp_row_s row_hit;
    lmp_pkg::lmp_row_s next_row_drive;

    always_comb begin
        row_en.pb = {portb_high_row_enable, portb_mid_row_enable, portb_low_row_enable};
        row_en.pc = {{5{papc_row_enable[5]}}, {8{papc_row_enable[4]}},
                     {8{papc_row_enable[3]}}};
        row_en.pa = {{8{papc_row_enable[2]}}, {8{papc_row_enable[1]}},
                     {8{papc_row_enable[0]}}};
        row_hit   = row_decode(row_sel);
        // fading: the row drops with the global enable
        next_row_drive.pb = (row_en.pb & row_hit.pb & {24{pwm_oe}}) ^ (row_en.pb & {24{pb_invert}});
        next_row_drive.pa = row_en.pa & row_hit.pa & {24{pwm_oe}};
        next_row_drive.pc = row_en.pc & row_hit.pc & {21{pwm_oe}};
    end

    logic [COLS-1:0] next_column_enable;
    assign next_column_enable = pin_word & {COLS{pwm_oe}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_drive     <= '0;
            row_select    <= 6'h00;
            column_enable <= '0;
        end else begin
            row_drive     <= next_row_drive;
            row_select    <= row_sel;
            column_enable <= next_column_enable;
        end
    end

    // each column drives a red, green and blue pin
    for (genvar c = 0; c < COLS; c++) begin : g_rgb
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                column_rgb_enable[3*c +: 3] <= 3'b000;
            end else begin
                column_rgb_enable[3*c +: 3] <= {3{next_column_enable[c]}};
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_dma_load;
        dma_word_loaded && dma_word_counter != 5'h00 && !(wr_fire && idx == `LMP_IDX_DMA_LEFT);
    endsequence

    dma_count_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_dma_load |=> dma_word_counter == $past(dma_word_counter) - 5'h01)
        else $error("dma counter did not step down");

    pbl_row_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (portb_low_row_enable == 8'h00) |=> (row_drive.pb[7:0] == 8'h00))
        else $error("disabled low port-b rows driven");

    pbm_row_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!pb_invert && portb_mid_row_enable == 8'h00) |=> (row_drive.pb[15:8] == 8'h00))
        else $error("disabled mid port-b rows driven");

    pbh_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pb_invert && !pwm_oe && portb_high_row_enable == 8'hFF) |=> row_drive.pb[23:16] == 8'hFF)
        else $error("inverted high port-b rows wrong");

    pc_top_row_a: assert property (@(posedge pclk) disable iff (!presetn)
        (row_sel == 6'h00 && pwm_oe && papc_row_enable[5]) |=> row_drive.pc[18])
        else $error("port-c row 18 not driven");

    pa_no_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pb_invert && !pwm_oe) |=> (row_drive.pa == 24'h000000 && row_drive.pc == 21'h000000))
        else $error("inversion leaked onto port-a or port-c");

    pa_row_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (row_sel == 6'h03 && pwm_oe && papc_row_enable[2]) |=> row_drive.pa[17])
        else $error("port-a row 17 not driven");

    pa_top_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (row_sel == 6'h05 && pwm_oe && papc_row_enable[2]) |=> row_drive.pa == 24'h080000)
        else $error("port-a row 19 not driven alone");

    col_zero_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        pwm_oe |=> column_enable[0] && column_rgb_enable[2:0] == 3'b111)
        else $error("column zero not enabled");

    col_zero_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && !pwrite && mapped && idx == `LMP_IDX_PWM_PIN) |=> prdata[0])
        else $error("column zero read as zero");

    dma_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && idx == `LMP_IDX_DMA_LEFT) |=> prdata[31:5] == 27'h0)
        else $error("dma counter upper bits not zero");

    col_high_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        pwm_oe ##1 pwm_oe |-> column_enable[15:8] == $past(column_pwm_enable[15:8]))
        else $error("high columns do not follow enables");

    oe_auto_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_entry && pwm_enable_auto_clear && !wr_fire) |=> !pwm_oe ##1 column_enable == '0)
        else $error("auto-clear did not shut columns");

    row_sel_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> row_select == $past(row_sel))
        else $error("row select output stale");

endmodule : lmp_top

// ---- test/lmp_matrix_model.sv ----
// ----------------------------------------
// led matrix columns: three rgb pins each
// ----------------------------------------
module lmp_matrix_model (
    input  wire logic [15:0] column_enable,
    input  wire logic [47:0] column_rgb_enable,
    output logic             rgb_match
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        rgb_match = 1'b1;
        for (int c = 0; c < 16; c++) begin
            // a column lights all three colour pins or none
            if (column_rgb_enable[3*c +: 3] !== {3{column_enable[c]}}) begin
                rgb_match = 1'b0;
            end
        end
    end
endmodule : lmp_matrix_model

// ---- test/lmp_top_tb_top.sv ----
`include "lmp_consts.svh"
module lmp_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // stimulus and observed ports
    // ----------------------------------------
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic [3:0]        pstrb = 4'hF;
    logic              dma_word_loaded = 1'b0;
    logic              irq_entry = 1'b0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    lmp_pkg::lmp_row_s row_drive;
    logic [5:0]        row_select;
    logic [15:0]       column_enable;
    logic [47:0]       column_rgb_enable;
    logic              rgb_match;
    int                n_mismatch = 0;
    int                checks_done = 0;
    always #2.5 pclk = ~pclk;
    lmp_top #(.COLS(16)) lmp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_word_loaded(dma_word_loaded), .irq_entry(irq_entry), .row_drive(row_drive),
        .row_select(row_select), .column_enable(column_enable), .column_rgb_enable(column_rgb_enable));
    lmp_matrix_model lmp_matrix_model_i (.column_enable(column_enable),
        .column_rgb_enable(column_rgb_enable), .rgb_match(rgb_match));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [68:0] exp, input logic [68:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // master holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {6'h00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 69'h1, 69'h0);
    endtask : apb
    task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, wd, rd, err);
    endtask : wr
    task automatic rdchk(input string what, input logic [3:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0000_0000, rd, err);
        chk(what, {37'h0, exp}, {37'h0, rd});
    endtask : rdchk
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : step
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdchk("dma reset", `LMP_IDX_DMA_LEFT, 32'h0000_0000);
        rdchk("com reset", `LMP_IDX_COM_E, 32'h0000_0000);
        rdchk("papc reset", `LMP_IDX_COM_E_PAPC, 32'h0000_0000);
        rdchk("pin reset", `LMP_IDX_PWM_PIN, 32'h0000_0001);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rows();
        wr(`LMP_IDX_PWM_OE, 32'h1);
        wr(`LMP_IDX_COM_E, 32'h0000_0101);
        wr(`LMP_IDX_ROW_SEL, 32'd16);
        step(2);
        chk("pb0 row", 69'h000001, row_drive.pb);
        chk("row sel", 69'd16, row_select);
        wr(`LMP_IDX_ROW_SEL, 32'd24);
        step(2);
        chk("pb8 row", 69'h000100, row_drive.pb);
        wr(`LMP_IDX_COM_E_PBH, 32'h1);
        wr(`LMP_IDX_ROW_SEL, 32'd8);
        step(2);
        chk("pb16 row", 69'h010000, row_drive.pb);
        wr(`LMP_IDX_KEY_CTRL, 32'h8);
        step(2);
        chk("pb invert", 69'h000101, row_drive.pb);
        wr(`LMP_IDX_COM_E_PAPC, 32'hFF);
        rdchk("papc bits", `LMP_IDX_COM_E_PAPC, 32'h3F);
        wr(`LMP_IDX_ROW_SEL, 32'd2);
        step(2);
        chk("pa16 row", 69'h010000, row_drive.pa);
        wr(`LMP_IDX_ROW_SEL, 32'd5);
        step(2);
        chk("pa19 row", 69'h080000, row_drive.pa);
        wr(`LMP_IDX_ROW_SEL, 32'd0);
        step(2);
        chk("pc18 row", 69'h040000, row_drive.pc);
        wr(`LMP_IDX_KEY_CTRL, 32'h0);
        // lane 1 only: the other three lanes must hold
        wr(`LMP_IDX_COM_E, 32'h0);
        pstrb <= 4'h2;
        wr(`LMP_IDX_COM_E, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        rdchk("lane mid", `LMP_IDX_COM_E_PBM, 32'hFF);
        rdchk("lane word", `LMP_IDX_COM_E, 32'h0000_FF00);
        $display("test rows done");
    endtask : t_rows
    task automatic t_cols();
        wr(`LMP_IDX_PWM_PIN, 32'h0000_AAAA);
        rdchk("pin word", `LMP_IDX_PWM_PIN, 32'h0000_AAAB);
        step(2);
        chk("col enable", 69'hAAAB, column_enable);
        chk("rgb triple", 69'h1, rgb_match);
        wr(`LMP_IDX_PWM_PIN, 32'h0);
        rdchk("col0 kept", `LMP_IDX_PWM_PIN, 32'h1);
        step(2);
        chk("col0 only", 69'h0001, column_enable);
        $display("test columns done");
    endtask : t_cols
    task automatic t_dma();
        wr(`LMP_IDX_DMA_LEFT, 32'hFF);
        rdchk("dma width", `LMP_IDX_DMA_LEFT, 32'h1F);
        @(posedge pclk);
        dma_word_loaded <= 1'b1;
        repeat (3) @(posedge pclk);
        dma_word_loaded <= 1'b0;
        rdchk("dma minus3", `LMP_IDX_DMA_LEFT, 32'h1C);
        wr(`LMP_IDX_DMA_LEFT, 32'h1);
        @(posedge pclk);
        dma_word_loaded <= 1'b1;
        repeat (2) @(posedge pclk);
        dma_word_loaded <= 1'b0;
        rdchk("dma floor", `LMP_IDX_DMA_LEFT, 32'h0);
        $display("test dma done");
    endtask : t_dma
    task automatic t_irq();
        logic [31:0] rd;
        logic        err;
        wr(`LMP_IDX_PWM_PIN, 32'hFFFF);
        wr(`LMP_IDX_FUNC_CTRL, 32'h0);
        @(posedge pclk);
        irq_entry <= 1'b1;
        @(posedge pclk);
        irq_entry <= 1'b0;
        step(3);
        chk("no autoclr", 69'hFFFF, column_enable);
        wr(`LMP_IDX_FUNC_CTRL, 32'h4);
        @(posedge pclk);
        irq_entry <= 1'b1;
        @(posedge pclk);
        irq_entry <= 1'b0;
        step(3);
        chk("autoclr col", 69'h0, column_enable);
        rdchk("autoclr oe", `LMP_IDX_PWM_OE, 32'h0);
        apb(1'b0, 4'h9, 32'h0, rd, err);
        chk("unmapped err", 69'h1, err);
        chk("unmapped data", 69'h0, rd);
        $display("test irq and unmapped done");
    endtask : t_irq
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rows();
        t_cols();
        t_dma();
        t_irq();
        tally_and_finish();
    end
    // whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #50000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : lmp_top_tb_top
